// ===== hw/fsrc_axil_slave.sv
`timescale 1ns/1ps
`include "fsrc_regs.svh"
module fsrc_axil_slave (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // write channels
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // read channels
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // sequencer side
  fsrc_cmd_if.regs cmd
);
  import fsrc_pkg::*;
  typedef struct packed {
    logic aw_got; logic [7:0] aw_addr;
    logic w_got; logic [31:0] w_data; logic [3:0] w_strb;
    logic bvalid; logic [1:0] bresp;
    logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    logic [31:0] ctrl; logic [31:0] addr; logic [31:0] data;
    logic [31:0] sdata; logic [31:0] saddr;
    logic start; logic [2:0] op; logic clr_ref; logic clr_ar;
  } fsrc_slv_t;
  fsrc_slv_t q, n;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic [7:0] wa;
  // byte lane mask from the strobes
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      assign wmask[8*i +: 8] = {8{wd[31] | 1'b1}} & {8{(q.w_got ? q.w_strb[i] : s_axi_wstrb_in[i])}};
    end
  endgenerate
  assign wd = q.w_got ? q.w_data : s_axi_wdata_in;
  assign wa = q.aw_got ? q.aw_addr : s_axi_awaddr_in;
  // handshakes
  assign s_axi_awready_out = !q.aw_got && !q.bvalid;
  assign s_axi_wready_out = !q.w_got && !q.bvalid;
  assign s_axi_arready_out = !q.rvalid;
  assign s_axi_bvalid_out = q.bvalid;
  assign s_axi_bresp_out = q.bresp;
  assign s_axi_rvalid_out = q.rvalid;
  assign s_axi_rdata_out = q.rdata;
  assign s_axi_rresp_out = q.rresp;
  assign cmd.start = q.start;
  assign cmd.op = fsrc_op_t'(q.op);
  assign cmd.addr = q.addr;
  assign cmd.wdata = q.data;
  assign cmd.seq_data = q.sdata;
  assign cmd.seq_addr = q.saddr;
  assign cmd.lock_done = q.ctrl[`FSRC_CTRL_LOCKED];
  assign cmd.rst_byte = q.ctrl[`FSRC_CTRL_RSTB_LSB +: 8];
  assign cmd.clr_refused = q.clr_ref;
  assign cmd.clr_autorst = q.clr_ar;
  // next state of the register slave
  always_comb begin
    logic aw_now;
    logic w_now;
    aw_now = q.aw_got | (s_axi_awvalid_in & s_axi_awready_out);
    w_now = q.w_got | (s_axi_wvalid_in & s_axi_wready_out);
    n = q;
    n.start = 1'b0;
    n.clr_ref = 1'b0;
    n.clr_ar = 1'b0;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata_in;
      n.w_strb = s_axi_wstrb_in;
    end
    if (q.bvalid && s_axi_bready_in) begin
      n.bvalid = 1'b0;
    end
    if (aw_now && w_now && !q.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `FSRC_RESP_OKAY;
      case (wa)
        `FSRC_OFF_CTRL: n.ctrl = (q.ctrl & ~wmask) | (wd & wmask);
        `FSRC_OFF_ADDR: n.addr = (q.addr & ~wmask) | (wd & wmask);
        `FSRC_OFF_DATA: n.data = (q.data & ~wmask) | (wd & wmask);
        `FSRC_OFF_SEQD: n.sdata = (q.sdata & ~wmask) | (wd & wmask);
        `FSRC_OFF_SEQA: n.saddr = (q.saddr & ~wmask) | (wd & wmask);
        `FSRC_OFF_CMD: begin
          n.start = wmask[0];
          n.op = wd[2:0];
        end
        `FSRC_OFF_STAT: begin
          n.clr_ref = wd[`FSRC_ST_REFUSED] & wmask[`FSRC_ST_REFUSED];
          n.clr_ar = wd[`FSRC_ST_AUTORST] & wmask[`FSRC_ST_AUTORST];
        end
        `FSRC_OFF_RDAT: ;
        default: n.bresp = `FSRC_RESP_SLVERR;
      endcase
    end
    if (q.rvalid && s_axi_rready_in) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      n.rvalid = 1'b1;
      n.rresp = `FSRC_RESP_OKAY;
      case (s_axi_araddr_in)
        `FSRC_OFF_CTRL: n.rdata = {16'h0000, q.ctrl[15:8], 7'h00, q.ctrl[0]};
        `FSRC_OFF_ADDR: n.rdata = q.addr;
        `FSRC_OFF_DATA: n.rdata = q.data;
        `FSRC_OFF_SEQD: n.rdata = q.sdata;
        `FSRC_OFF_SEQA: n.rdata = q.saddr;
        `FSRC_OFF_CMD: n.rdata = `FSRC_ZERO;
        `FSRC_OFF_STAT: n.rdata = cmd.status;
        `FSRC_OFF_RDAT: n.rdata = 32'(cmd.rdata);
        default: begin
          n.rdata = `FSRC_ZERO;
          n.rresp = `FSRC_RESP_SLVERR;
        end
      endcase
    end
  end
  // state register
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule : fsrc_axil_slave

// ===== hw/fsrc_cmd_if.sv
`timescale 1ns/1ps
// register side to sequencer side
interface fsrc_cmd_if #(parameter int ADDR_W = 22, parameter int DATA_W = 16);
  logic start;
  fsrc_pkg::fsrc_op_t op;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] seq_data;
  logic [31:0] seq_addr;
  logic lock_done;
  logic [7:0] rst_byte;
  logic clr_refused;
  logic clr_autorst;
  logic [31:0] status;
  logic [DATA_W-1:0] rdata;
  modport regs(output start, op, addr, wdata, seq_data, seq_addr, lock_done,
    rst_byte, clr_refused, clr_autorst, input status, rdata);
  modport core(input start, op, addr, wdata, seq_data, seq_addr, lock_done,
    rst_byte, clr_refused, clr_autorst, output status, rdata);
endinterface : fsrc_cmd_if

// ===== hw/fsrc_ctrl.sv
`timescale 1ns/1ps
`include "fsrc_regs.svh"
// Notes on behaviour
// - lock: enter sequence, then protect algorithm, reset pin high allowed.
// - host exits region after locking before touching the array.
// - write only with select and write strobe low, output enable high.
// - timeout flag high during operation: host writes the reset command.
// - autoselect only issued in read or suspend-read, never while busy.
// - leaving the region takes a four-cycle exit sequence.
module fsrc_ctrl #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16,
  parameter int WE_CYCLES = `FSRC_WE_MIN_CYC,
  parameter int RD_CYCLES = `FSRC_RD_CYC,
  parameter int RST_CYCLES = `FSRC_RST_CYC,
  parameter int REC_CYCLES = `FSRC_REC_CYC
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // register bus
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // flash pins
  output logic [ADDR_W-1:0] flash_addr_out,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic flash_reset_n_out,
  input wire logic flash_busy_in
);
  import fsrc_pkg::*;
  localparam int CNT_W = 8;
  typedef struct packed {
    fsrc_st_t st; fsrc_op_t op; logic [1:0] step; logic [1:0] last;
    logic [CNT_W-1:0] cnt; logic auto_rst;
    logic secure; logic autosel; logic refused; logic autorst;
    logic [DATA_W-1:0] rdata; logic [ADDR_W-1:0] addr; logic [DATA_W-1:0] dq;
    logic dq_oe; logic ce_n; logic we_n; logic oe_n; logic reset_n;
  } fsrc_core_t;
  fsrc_core_t q, n;
  fsrc_cmd_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cmd ();
  // ****************************************
  // register slave
  // ****************************************
  fsrc_axil_slave u_regs (
    .core_clk_in(core_clk_in), .rst_in(rst_in),
    .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in), .cmd(cmd.regs)
  );
  // status word and read data
  assign cmd.rdata = q.rdata;
  assign cmd.status = {25'h000_0000, flash_busy_in, q.rdata[`FSRC_DQ_LOCK],
    q.autorst, q.refused, q.autosel, q.secure, q.st != ST_IDLE};
  // pins straight from flip-flops
  assign flash_addr_out = q.addr;
  assign flash_dq_out = q.dq;
  assign flash_dq_oe_out = q.dq_oe;
  assign flash_ce_n_out = q.ce_n;
  assign flash_we_n_out = q.we_n;
  assign flash_oe_n_out = q.oe_n;
  assign flash_reset_n_out = q.reset_n;
  // ****************************************
  // bus cycle sequencer
  // ****************************************
  always_comb begin
    logic [1:0] stp;
    logic [ADDR_W-1:0] sa;
    logic [DATA_W-1:0] sd;
    sa = '0;
    stp = (q.st == ST_IDLE) ? 2'd0 : q.step + 2'd1;
    // address and data of a sequence cycle
    case (stp)
      2'd0: sa = ADDR_W'(cmd.seq_addr[15:0]);
      2'd1: sa = ADDR_W'(cmd.seq_addr[31:16]);
      2'd2: sa = ADDR_W'(cmd.seq_addr[15:0]);
      default: sa = cmd.addr[ADDR_W-1:0];
    endcase
    sd = DATA_W'(cmd.seq_data[8*stp +: 8]);
    n = q;
    // sticky clears first, so a same-cycle set wins
    if (cmd.clr_refused) n.refused = 1'b0;
    if (cmd.clr_autorst) n.autorst = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (cmd.start) begin
          n.op = cmd.op;
          n.step = 2'd0;
          n.auto_rst = 1'b0;
          if (cmd.op == OP_AUTOSEL && flash_busy_in) begin
            n.refused = 1'b1;
          end else if ((cmd.op == OP_READ || cmd.op == OP_WRITE) && q.secure
                       && cmd.lock_done) begin
            n.refused = 1'b1;
          end else if (cmd.op == OP_HWRST) begin
            // modes drop as the pin falls, never secure with the pin low
            n.secure = 1'b0;
            n.autosel = 1'b0;
            n.reset_n = 1'b0;
            n.cnt = CNT_W'(RST_CYCLES - 1);
            n.st = ST_RST;
          end else if (cmd.op == OP_READ) begin
            n.addr = cmd.addr[ADDR_W-1:0];
            n.ce_n = 1'b0;
            n.oe_n = 1'b0;
            n.cnt = CNT_W'(RD_CYCLES - 1);
            n.st = ST_RLOW;
          end else if (cmd.op == OP_WRITE) begin
            n.addr = cmd.addr[ADDR_W-1:0];
            n.dq = cmd.wdata[DATA_W-1:0];
            n.last = 2'd0;
            n.st = ST_SETUP;
          end else begin
            // three-cycle sequences, exit has a fourth
            n.addr = sa;
            n.dq = sd;
            n.last = (cmd.op == OP_EXIT) ? 2'd3 : 2'd2;
            n.st = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        // write strobe only with select low and outputs off
        n.ce_n = 1'b0;
        n.we_n = 1'b0;
        n.oe_n = 1'b1;
        n.dq_oe = 1'b1;
        n.cnt = CNT_W'(WE_CYCLES - 1);
        n.st = ST_WLOW;
      end
      ST_WLOW: begin
        if (q.cnt == '0) begin
          n.we_n = 1'b1;
          n.st = ST_WEND;
        end else begin
          n.cnt = q.cnt - 1'b1;
        end
      end
      ST_WEND: begin
        n.ce_n = 1'b1;
        n.dq_oe = 1'b0;
        if (q.step == q.last) begin
          n.st = ST_IDLE;
          if (q.op == OP_ENTER) n.secure = 1'b1;
          if (q.op == OP_EXIT) n.secure = 1'b0;
          if (q.op == OP_AUTOSEL) n.autosel = 1'b1;
          if (q.op == OP_WRITE && q.dq[7:0] == cmd.rst_byte) n.autosel = 1'b0;
          if (q.auto_rst) n.autorst = 1'b1;
        end else begin
          n.step = q.step + 2'd1;
          n.addr = sa;
          n.dq = sd;
          n.st = ST_SETUP;
        end
      end
      ST_RLOW: begin
        if (q.cnt == '0) begin
          n.rdata = flash_dq_in;
          n.ce_n = 1'b1;
          n.oe_n = 1'b1;
          n.st = ST_IDLE;
          // timeout seen while busy: issue the reset command at once
          if (flash_busy_in && flash_dq_in[`FSRC_DQ_TIMEOUT]) begin
            n.op = OP_WRITE;
            n.dq = DATA_W'(cmd.rst_byte);
            n.auto_rst = 1'b1;
            n.step = 2'd0;
            n.last = 2'd0;
            n.st = ST_SETUP;
          end
        end else begin
          n.cnt = q.cnt - 1'b1;
        end
      end
      ST_RST: begin
        if (q.cnt == '0) begin
          n.reset_n = 1'b1;
          n.secure = 1'b0;
          n.autosel = 1'b0;
          n.cnt = CNT_W'(REC_CYCLES - 1);
          n.st = ST_REC;
        end else begin
          n.cnt = q.cnt - 1'b1;
        end
      end
      ST_REC: begin
        if (q.cnt == '0) n.st = ST_IDLE;
        else n.cnt = q.cnt - 1'b1;
      end
      default: n.st = ST_IDLE;
    endcase
  end
  // state register, select, strobes and reset pin idle high, data drive off
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '{st: ST_IDLE, op: OP_READ, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
        reset_n: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  logic [CNT_W-1:0] wlen;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) wlen <= '0;
    else wlen <= flash_we_n_out ? '0 : wlen + 1'b1;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_write_strobe_ok: assert property (
    !flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out)
    else $error("write strobe without select or with output enable");
  a_bus_no_fight: assert property (
    flash_dq_oe_out |-> flash_oe_n_out && $past(flash_oe_n_out))
    else $error("data driven while outputs enabled");
  a_we_width: assert property (
    $rose(flash_we_n_out) |-> wlen >= CNT_W'(WE_CYCLES))
    else $error("write strobe too short");
  a_reset_pin_high: assert property (
    q.secure |-> flash_reset_n_out)
    else $error("reset pin low in security mode");
  a_autosel_refuse: assert property (
    q.st == ST_IDLE && cmd.start && cmd.op == OP_AUTOSEL && flash_busy_in
    |=> q.refused && q.st == ST_IDLE && flash_we_n_out)
    else $error("autoselect issued while device busy");
  a_locked_refuse: assert property (
    q.st == ST_IDLE && cmd.start && cmd.op == OP_READ && q.secure && cmd.lock_done
    |=> q.refused && flash_ce_n_out)
    else $error("array access before region exit");
  a_timeout_reset: assert property (
    q.st == ST_RLOW && q.cnt == '0 && flash_busy_in && flash_dq_in[`FSRC_DQ_TIMEOUT]
    |-> ##[2:3] !flash_we_n_out && flash_dq_out[7:0] == cmd.rst_byte)
    else $error("no reset command after timeout flag");
  a_exit_four: assert property (
    $fell(q.secure) && flash_reset_n_out |-> $past(q.step) == 2'd3)
    else $error("region left without four-cycle exit");
  c_enter: cover property ($rose(q.secure));
  c_autosel: cover property ($rose(q.autosel));
  c_autorst: cover property ($rose(q.autorst));
  c_hwreset: cover property ($rose(flash_reset_n_out));
endmodule : fsrc_ctrl

// ===== hw/fsrc_pkg.sv
package fsrc_pkg;
  // ****************************************
  // operations and sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    OP_READ = 3'b000, OP_WRITE = 3'b001, OP_ENTER = 3'b010,
    OP_AUTOSEL = 3'b011, OP_EXIT = 3'b100, OP_HWRST = 3'b101
  } fsrc_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_WLOW = 3'b010, ST_WEND = 3'b011,
    ST_RLOW = 3'b100, ST_RST = 3'b101, ST_REC = 3'b110
  } fsrc_st_t;
endpackage : fsrc_pkg

// ===== hw/fsrc_regs.svh
`ifndef FSRC_REGS_SVH
`define FSRC_REGS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define FSRC_OFF_CTRL 8'h00
`define FSRC_OFF_ADDR 8'h04
`define FSRC_OFF_DATA 8'h08
`define FSRC_OFF_SEQD 8'h0C
`define FSRC_OFF_SEQA 8'h10
`define FSRC_OFF_CMD 8'h14
`define FSRC_OFF_STAT 8'h18
`define FSRC_OFF_RDAT 8'h1C
// ****************************************
// fields, reset values, responses
// ****************************************
`define FSRC_CTRL_LOCKED 0
`define FSRC_CTRL_RSTB_LSB 8
`define FSRC_ST_BUSY 0
`define FSRC_ST_SECURE 1
`define FSRC_ST_AUTOSEL 2
`define FSRC_ST_REFUSED 3
`define FSRC_ST_AUTORST 4
`define FSRC_ST_LOCKIND 5
`define FSRC_ST_DEVBUSY 6
`define FSRC_DQ_LOCK 7
`define FSRC_DQ_TIMEOUT 5
`define FSRC_ZERO 32'h0000_0000
`define FSRC_RESP_OKAY 2'h0
`define FSRC_RESP_SLVERR 2'h2
// ****************************************
// timing
// ****************************************
`define FSRC_CLK_NS 20
`define FSRC_GLITCH_NS 5
`define FSRC_WE_MIN_CYC ((`FSRC_GLITCH_NS + `FSRC_CLK_NS - 1) / `FSRC_CLK_NS)
`define FSRC_RD_CYC 4
`define FSRC_RST_CYC 25
`define FSRC_REC_CYC 25
`endif

// ===== test/fsrc_ctrl_tb.sv
`timescale 1ns/1ps
`include "fsrc_regs.svh"
module fsrc_ctrl_tb;
  import fsrc_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic hold_busy = 1'b0, stall = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ce_n, we_n, oe_n, rst_n, oe, mbusy;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, st, rd;
  logic [21:0] faddr;
  logic [15:0] fdq_o, fdq_i;
  int err_count = 0, samples_checked = 0, w0;
  // data wire resolved from both drivers
  wire [15:0] dq_bus = oe ? fdq_o : fdq_i;
  always #10 core_clk_in = ~core_clk_in;
  fsrc_ctrl u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .flash_addr_out(faddr), .flash_dq_out(fdq_o),
    .flash_dq_oe_out(oe), .flash_dq_in(dq_bus), .flash_ce_n_out(ce_n), .flash_we_n_out(we_n),
    .flash_oe_n_out(oe_n), .flash_reset_n_out(rst_n), .flash_busy_in(hold_busy | mbusy));
  fsrc_flash_model u_flash (.addr_in(faddr), .dq_in(dq_bus[7:0]), .ce_n_in(ce_n),
    .we_n_in(we_n), .oe_n_in(oe_n), .reset_n_in(rst_n), .dq_out(fdq_i), .busy_out(mbusy),
    .stall_in(stall));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic hang();
    err_count++;
    $display("MISMATCH %0t wait ran out", $time);
    stop_test();
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (50) begin
      @(posedge core_clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        rs = bresp;
        return;
      end
    end
    hang();
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge core_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (50) begin
      @(posedge core_clk_in);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
        return;
      end
    end
    hang();
  endtask : rd_reg
  // one sequencer operation, waits until idle
  task automatic op(input fsrc_op_t o, input logic [31:0] a, input logic [31:0] d);
    wr(`FSRC_OFF_ADDR, a);
    wr(`FSRC_OFF_DATA, d);
    wr(`FSRC_OFF_CMD, {29'h0000_0000, o});
    repeat (50) begin
      rd_reg(`FSRC_OFF_STAT);
      st = rd;
      if (rd[`FSRC_ST_BUSY] === 1'b0) return;
    end
    hang();
  endtask : op
  task automatic rd_flash(input logic [31:0] a);
    op(OP_READ, a, 32'h0000_0000);
    rd_reg(`FSRC_OFF_RDAT);
  endtask : rd_flash
  task automatic seq(input logic [7:0] c, input logic [7:0] d2);
    wr(`FSRC_OFF_SEQD, {8'h00, c, d2, u_flash.D1});
  endtask : seq
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rd_reg(`FSRC_OFF_STAT);
    chk(rd, 32'h0000_0000);
    rd_reg(8'h40);
    chk(32'(rs), 32'(`FSRC_RESP_SLVERR));
    chk(rd, 32'h0000_0000);
    wr(8'h44, 32'h0000_0001);
    chk(32'(rs), 32'(`FSRC_RESP_SLVERR));
    wr(`FSRC_OFF_SEQA, {u_flash.UA2[15:0], u_flash.UA1[15:0]});
    chk(32'(rs), 32'(`FSRC_RESP_OKAY));
    wr(`FSRC_OFF_CTRL, {16'h0000, u_flash.C_RST, 8'h00});
    rd_reg(`FSRC_OFF_SEQA);
    chk(rd, {u_flash.UA2[15:0], u_flash.UA1[15:0]});
  endtask : t_regs
  task automatic t_secure();
    w0 = u_flash.wr_cnt;
    seq(u_flash.C_ENT, u_flash.D2);
    op(OP_ENTER, 32'h0000_0000, 32'h0000_0000);
    chk(u_flash.wr_cnt - w0, 3);
    chk(32'(st[`FSRC_ST_SECURE]), 1);
    rd_flash(32'h0000_0003);
    chk(rd, {16'h0000, u_flash.SERIAL | 16'h0003});
    wr(`FSRC_OFF_CTRL, {16'h0000, u_flash.C_RST, 8'h01});
    op(OP_READ, 32'h0000_0003, 32'h0000_0000);
    chk(32'(st[`FSRC_ST_REFUSED]), 1);
    wr(`FSRC_OFF_STAT, 32'h0000_0008);
    seq(u_flash.C_EXT, u_flash.D2);
    op(OP_EXIT, 32'h0000_0000, 32'h0000_0000);
    chk(32'(u_flash.secure), 0);
    chk(32'(st[`FSRC_ST_SECURE]), 0);
    rd_flash(32'h0000_0003);
    chk(rd, 32'h0000_FFFC);
    wr(`FSRC_OFF_CTRL, {16'h0000, u_flash.C_RST, 8'h00});
  endtask : t_secure
  task automatic t_autosel();
    seq(u_flash.C_AUT, u_flash.D2);
    op(OP_AUTOSEL, 32'h0000_0000, 32'h0000_0000);
    chk(32'(st[`FSRC_ST_AUTOSEL]), 1);
    rd_flash(32'h0000_0000);
    chk(rd, 32'(u_flash.MAKER));
    rd_flash(32'h0000_0001);
    chk(rd, 32'(u_flash.PART));
    rd_flash(32'h0000_0002);
    chk(rd, 32'(u_flash.LOCKED));
    rd_flash(32'h0000_0003);
    rd_reg(`FSRC_OFF_STAT);
    chk(32'(rd[`FSRC_ST_LOCKIND]), 32'(u_flash.LOCKED));
    op(OP_WRITE, 32'h0012_3456, 32'(u_flash.C_RST));
    chk(32'(st[`FSRC_ST_AUTOSEL]), 0);
    rd_flash(32'h0000_0000);
    chk(rd, 32'h0000_FFFF);
  endtask : t_autosel
  task automatic t_refuse();
    hold_busy <= 1'b1;
    w0 = u_flash.wr_cnt;
    op(OP_AUTOSEL, 32'h0000_0000, 32'h0000_0000);
    chk(32'(st[`FSRC_ST_REFUSED]), 1);
    chk(u_flash.wr_cnt - w0, 0);
    hold_busy <= 1'b0;
    wr(`FSRC_OFF_STAT, 32'h0000_0008);
    rd_reg(`FSRC_OFF_STAT);
    chk(32'(rd[`FSRC_ST_REFUSED]), 0);
  endtask : t_refuse
  task automatic t_timeout();
    stall <= 1'b1;
    rd_flash(32'h0000_0005);
    chk(32'(rd[`FSRC_DQ_TIMEOUT]), 1);
    rd_reg(`FSRC_OFF_STAT);
    chk(32'(rd[`FSRC_ST_AUTORST]), 1);
    chk(32'(u_flash.stuck), 0);
    stall <= 1'b0;
  endtask : t_timeout
  task automatic t_hwrst();
    seq(u_flash.C_ENT, ~u_flash.D2);
    op(OP_ENTER, 32'h0000_0000, 32'h0000_0000);
    chk(32'(u_flash.secure), 0);
    seq(u_flash.C_ENT, u_flash.D2);
    op(OP_ENTER, 32'h0000_0000, 32'h0000_0000);
    chk(32'(u_flash.secure), 1);
    op(OP_HWRST, 32'h0000_0000, 32'h0000_0000);
    chk(32'(u_flash.secure), 0);
    chk(32'(st[`FSRC_ST_SECURE]), 0);
    rd_flash(32'h0000_0003);
    chk(rd, 32'h0000_FFFC);
  endtask : t_hwrst
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_secure();
    t_autosel();
    t_refuse();
    t_timeout();
    t_hwrst();
    stop_test();
  end
endmodule : fsrc_ctrl_tb

// ===== test/fsrc_flash_model.sv
`timescale 1ns/1ps
// ****************************************
// flash device model on the far side
// ****************************************
module fsrc_flash_model #(
  parameter logic [21:0] UA1 = 22'h00_0011,
  parameter logic [21:0] UA2 = 22'h00_0022,
  parameter logic [7:0] D1 = 8'hA1,
  parameter logic [7:0] D2 = 8'h5E,
  parameter logic [7:0] C_ENT = 8'h3C,
  parameter logic [7:0] C_AUT = 8'h4D,
  parameter logic [7:0] C_EXT = 8'h6B,
  parameter logic [7:0] C_RST = 8'hE7,
  parameter logic [15:0] MAKER = 16'h00C5, // arbitrary value
  parameter logic [15:0] PART = 16'h0077, // arbitrary value
  parameter logic [15:0] SERIAL = 16'h5A00,
  parameter logic LOCKED = 1'b1
) (
  // bus pins
  input wire logic [21:0] addr_in,
  input wire logic [7:0] dq_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic reset_n_in,
  output logic [15:0] dq_out,
  output logic busy_out,
  // fault request
  input wire logic stall_in
);
  logic secure = 1'b0;
  logic autosel = 1'b0;
  logic stuck = 1'b0;
  logic [1:0] cnt = 2'h0;
  logic [21:0] la = 22'h00_0000;
  logic [15:0] word;
  logic [15:0] last = 16'h0000;
  int wr_cnt = 0;
  realtime t_fall = 0;
  wire drive = !ce_n_in && !oe_n_in && reset_n_in;
  wire strobe_n = ce_n_in | we_n_in;
  assign busy_out = stuck;
  // released bus shows inverse of last value
  assign dq_out = drive ? word : ~last;
  always @(word, drive) if (drive) last = word;
  always @(posedge stall_in) stuck = 1'b1;
  // address on the later falling edge
  always @(negedge strobe_n) begin
    la = addr_in;
    t_fall = $realtime;
  end
  // data on the first rising edge, glitches and read cycles ignored
  always @(posedge strobe_n) begin
    if (oe_n_in && reset_n_in && $realtime - t_fall >= 5.0) take(la, dq_in);
  end
  // hardware reset drops region and autoselect modes
  always @(negedge reset_n_in) begin
    secure = 1'b0;
    autosel = 1'b0;
    cnt = 2'h0;
  end
  // command sequence decoder
  task automatic take(input logic [21:0] a, input logic [7:0] d);
    wr_cnt++;
    if (d == C_RST) begin
      cnt = 2'h0;
      autosel = 1'b0;
      stuck = 1'b0;
    end else if (cnt == 2'h0 && a == UA1 && d == D1) begin
      cnt = 2'h1;
    end else if (cnt == 2'h1 && a == UA2 && d == D2) begin
      cnt = 2'h2;
    end else if (cnt == 2'h2 && a == UA1 && d == C_ENT) begin
      secure = 1'b1;
      cnt = 2'h0;
    end else if (cnt == 2'h2 && a == UA1 && d == C_AUT && !stuck) begin
      autosel = 1'b1;
      cnt = 2'h0;
    end else if (cnt == 2'h2 && a == UA1 && d == C_EXT && secure) begin
      cnt = 2'h3;
    end else begin
      if (cnt == 2'h3 && d == 8'h00) secure = 1'b0;
      cnt = 2'h0;
    end
  endtask : take
  // read data with region and autoselect overlays
  always_comb begin
    if (stuck) word = 16'h0020;
    else if (autosel && addr_in[7:0] == 8'h00) word = MAKER;
    else if (autosel && addr_in[7:0] == 8'h01) word = PART;
    else if (autosel && addr_in[7:0] == 8'h02) word = {15'h0000, LOCKED};
    else if (autosel) word = {8'h00, LOCKED, 7'h00};
    else if (secure && addr_in < 22'h00_0008) word = SERIAL | addr_in[15:0];
    else word = ~addr_in[15:0];
  end
endmodule : fsrc_flash_model
